// ==== core/vlan_qos_core.sv ====
`timescale 1ns/1ps
module vlan_qos_core #(
  parameter  int NPORTS = 4,
  parameter  int NVLAN  = 8,
  localparam int PW     = $clog2(NPORTS),
  localparam int VW     = $clog2(NVLAN)
) (
  input  wire logic                           i_sys_clk,
  input  wire logic                           i_rst,
  input  wire logic [7:0]                     i_avs_address,
  input  wire logic                           i_avs_read,
  input  wire logic                           i_avs_write,
  input  wire logic [31:0]                    i_avs_writedata,
  input  wire logic [3:0]                     i_avs_byteenable,
  output logic      [31:0]                    o_avs_readdata,
  output logic                                o_avs_waitrequest,
  input  wire logic                           i_frm_valid,
  input  wire logic [PW-1:0]                  i_frm_in_port,
  input  wire logic [PW-1:0]                  i_frm_out_port,
  input  wire logic                           i_frm_tagged,
  input  wire logic [vlan_qos_pkg::VID_W-1:0] i_frm_vid,
  input  wire logic [vlan_qos_pkg::PCP_W-1:0] i_frm_pcp,
  output logic                                o_dec_valid,
  output logic                                o_dec_drop,
  output logic      [1:0]                     o_dec_action,
  output logic      [vlan_qos_pkg::VID_W-1:0] o_dec_vid,
  output logic      [vlan_qos_pkg::PCP_W-1:0] o_dec_pcp,
  output logic      [vlan_qos_pkg::Q_W-1:0]   o_dec_queue,
  input  wire logic                           i_sched_req,
  input  wire logic [vlan_qos_pkg::NQ-1:0]    i_q_pending,
  output logic                                o_grant_valid,
  output logic      [vlan_qos_pkg::Q_W-1:0]   o_grant_queue,
  output logic      [NPORTS-1:0]              o_rx_rate_10m,
  output logic      [NPORTS-1:0]              o_tx_rate_10m
);
  import vlan_qos_pkg::*;

  // register bus, one wait cycle per access
  logic              wait_q;
  logic [31:0]       rdata_q;
  logic [3:0]        gbl_q;
  logic [15:0]       drops_q;
  logic [15:0]       tagmap_q;
  logic [11:0]       remark_q;
  logic [27:0]       weight_q;
  logic [2:0]        sched_q;
  logic [PC_W-1:0]   pcfg_q [NPORTS];
  logic [31:0]       ve_q   [NVLAN];

  wire               bus_req  = i_avs_read | i_avs_write;
  wire               wr_go    = i_avs_write & ~wait_q &
                                (i_avs_byteenable == 4'hF);
  wire [PW-1:0]      port_idx = i_avs_address[PW+1:2];
  wire [VW-1:0]      vlan_idx = i_avs_address[VW+1:2];
  wire               port_hit = (i_avs_address[7:4] == PORT_PAGE) &&
                                ({1'b0, i_avs_address[3:2]} < 3'(NPORTS));
  wire               vlan_hit = (i_avs_address[7:6] == VLAN_PAGE) &&
                                ({1'b0, i_avs_address[5:2]} < 5'(NVLAN));
  wire               wr_gbl   = wr_go && (i_avs_address == OFS_GLOBAL);
  wire               wr_drops = wr_go && (i_avs_address == OFS_DROPS);
  wire               wr_tmap  = wr_go && (i_avs_address == OFS_TAGMAP);
  wire               wr_rmk   = wr_go && (i_avs_address == OFS_REMARK);
  wire               wr_wgt   = wr_go && (i_avs_address == OFS_WEIGHT);
  wire               wr_sched = wr_go && (i_avs_address == OFS_SCHED);
  wire [VID_W-1:0]   wr_pvid  = i_avs_writedata[VID_W-1:0];
  wire               pvid_ok  = (wr_pvid >= VID_MIN) && (wr_pvid <= VID_MAX);
  wire [31:0]        ve_mask  = (32'h0000_0001 << VE_VALID) |
                                ((32'h0000_0001 << (VE_MEMB_LSB + NPORTS)) -
                                 (32'h0000_0001 << VE_MEMB_LSB)) |
                                32'h0000_0FFF;
  wire [31:0]        port_word = 32'(pcfg_q[port_idx]);
  wire [31:0]        vlan_word = ve_q[vlan_idx];
  wire [31:0]        rd_word   =
    port_hit                        ? port_word :
    vlan_hit                        ? vlan_word :
    (i_avs_address == OFS_GLOBAL)   ? 32'(gbl_q) :
    (i_avs_address == OFS_DROPS)    ? 32'(drops_q) :
    (i_avs_address == OFS_TAGMAP)   ? 32'(tagmap_q) :
    (i_avs_address == OFS_REMARK)   ? 32'(remark_q) :
    (i_avs_address == OFS_WEIGHT)   ? 32'(weight_q) :
    (i_avs_address == OFS_SCHED)    ? 32'(sched_q) : 32'h0000_0000;

  // a zero weight would starve its queue, so that field keeps its value
  logic [27:0] wgt_new;
  logic [NQ-1:0] wgt_nz;
  genvar gq;
  for (gq = 0; gq < NQ; gq++) begin : g_wgt
    wire [WGT_W-1:0] wfield = i_avs_writedata[WGT_W*gq +: WGT_W];
    assign wgt_new[WGT_W*gq +: WGT_W] = (wfield != 7'h00) ? wfield :
                                        weight_q[WGT_W*gq +: WGT_W];
    assign wgt_nz[gq] = weight_q[WGT_W*gq +: WGT_W] != 7'h00;
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      wait_q  <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end else begin
      wait_q <= ~(bus_req & wait_q);
      if (bus_req & wait_q) begin
        rdata_q <= rd_word;
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      gbl_q    <= GLOBAL_RST;
      tagmap_q <= TAGMAP_RST;
      remark_q <= REMARK_RST;
      weight_q <= WEIGHT_RST;
      sched_q  <= SCHED_RST;
    end else begin
      if (wr_gbl)   gbl_q    <= i_avs_writedata[3:0];
      if (wr_tmap)  tagmap_q <= i_avs_writedata[15:0];
      if (wr_rmk)   remark_q <= i_avs_writedata[11:0];
      if (wr_wgt)   weight_q <= wgt_new;
      if (wr_sched) sched_q  <= i_avs_writedata[2:0];
    end
  end

  genvar gp;
  for (gp = 0; gp < NPORTS; gp++) begin : g_port
    wire wr_this = wr_go && port_hit && (port_idx == PW'(gp));
    always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
        pcfg_q[gp] <= PORT_RST;
      end else if (wr_this) begin
        pcfg_q[gp][PC_W-1:VID_W] <= i_avs_writedata[PC_W-1:VID_W];
        if (pvid_ok) begin
          pcfg_q[gp][VID_W-1:0] <= wr_pvid;
        end
      end
    end
    // independent rate per direction and port
    assign o_rx_rate_10m[gp] = pcfg_q[gp][PC_RX10];
    assign o_tx_rate_10m[gp] = pcfg_q[gp][PC_TX10];
    a_pvid_range: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      pcfg_q[gp][VID_W-1:0] >= VID_MIN && pcfg_q[gp][VID_W-1:0] <= VID_MAX)
      else $error("port default vid out of range");
  end

  genvar ge;
  for (ge = 0; ge < NVLAN; ge++) begin : g_vtab
    wire wr_this = wr_go && vlan_hit && (vlan_idx == VW'(ge));
    always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
        ve_q[ge] <= 32'h0000_0000;
      end else if (wr_this) begin
        ve_q[ge] <= i_avs_writedata & ve_mask;
      end
    end
  end

  assign o_avs_readdata    = rdata_q;
  assign o_avs_waitrequest = wait_q;

  // frame decision, one cycle from descriptor to answer
  wire               vlan_en   = gbl_q[GBL_VLAN_EN];
  wire [PC_W-1:0]    in_cfg    = pcfg_q[i_frm_in_port];
  wire [PC_W-1:0]    out_cfg   = pcfg_q[i_frm_out_port];
  wire [VID_W-1:0]   in_pvid   = in_cfg[VID_W-1:0];
  wire [VID_W-1:0]   cls_vid   = (gbl_q[GBL_TAG_AWARE] && i_frm_tagged) ?
                                 i_frm_vid : in_pvid;
  logic [NVLAN-1:0]  in_memb;
  logic [NVLAN-1:0]  out_memb;
  for (ge = 0; ge < NVLAN; ge++) begin : g_look
    wire hit = ve_q[ge][VE_VALID] && (ve_q[ge][VID_W-1:0] == cls_vid);
    wire [NPORTS-1:0] memb = ve_q[ge][VE_MEMB_LSB +: NPORTS];
    assign in_memb[ge]  = hit && memb[i_frm_in_port];
    assign out_memb[ge] = hit && memb[i_frm_out_port];
  end
  wire in_member  = |in_memb;
  wire out_member = |out_memb;
  wire drop_w     = vlan_en && ((gbl_q[GBL_TAG_ONLY] && !i_frm_tagged) ||
                    (gbl_q[GBL_FILTER] && !in_member) ||
                    !out_member);

  wire qos_mode_t    in_qmode  = qos_mode_t'(in_cfg[PC_QMODE_LSB +: 2]);
  wire [Q_W-1:0]     port_prio = in_cfg[PC_PRIO_LSB +: Q_W];
  wire [Q_W-1:0]     tag_queue = tagmap_q[{i_frm_pcp, 1'b0} +: Q_W];
  wire [Q_W-1:0]     queue_w   =
    (in_qmode == QOS_PORT_PRIORITY_MODE) ? port_prio :
    (in_qmode == QOS_TAG) ? (i_frm_tagged ? tag_queue : port_prio)
                          : 2'h0;
  wire [PCP_W-1:0]   remark_pcp = remark_q[PCP_W*queue_w +: PCP_W];
  wire egress_mode_t out_emode  = egress_mode_t'(out_cfg[PC_EMODE_LSB +: 2]);
  wire               rewrite_en = out_cfg[PC_REWRITE];

  tag_action_t action_w;
  always_comb begin
    action_w = ACT_KEEP;
    if (vlan_en) begin
      case (out_emode)
        EGR_UNMOD: action_w = ACT_KEEP;
        EGR_UNTAG: action_w = i_frm_tagged ? ACT_STRIP : ACT_KEEP;
        EGR_TAG:   action_w = i_frm_tagged ? ACT_KEEP : ACT_INSERT;
        EGR_RETAG: action_w = i_frm_tagged ? ACT_REPLACE : ACT_INSERT;
        default:   action_w = ACT_KEEP;
      endcase
    end
  end

  wire new_tag = (action_w == ACT_INSERT) || (action_w == ACT_REPLACE);
  wire [VID_W-1:0] vid_w = new_tag ? in_pvid : i_frm_vid;
  wire [PCP_W-1:0] pcp_w =
    (action_w == ACT_INSERT) ? remark_pcp :
    ((action_w == ACT_REPLACE) && rewrite_en) ? remark_pcp :
    i_frm_pcp;

  logic            dvalid_q;
  logic            ddrop_q;
  logic [1:0]      daction_q;
  logic [VID_W-1:0] dvid_q;
  logic [PCP_W-1:0] dpcp_q;
  logic [Q_W-1:0]  dqueue_q;
  wire             count_drop = i_frm_valid && drop_w;

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      dvalid_q  <= 1'b0;
      ddrop_q   <= 1'b0;
      daction_q <= 2'h0;
      dvid_q    <= 12'h000;
      dpcp_q    <= 3'h0;
      dqueue_q  <= 2'h0;
    end else begin
      dvalid_q <= i_frm_valid;
      if (i_frm_valid) begin
        ddrop_q   <= drop_w;
        daction_q <= action_w;
        dvid_q    <= vid_w;
        dpcp_q    <= pcp_w;
        dqueue_q  <= queue_w;
      end
    end
  end

  // a drop in the clearing cycle is counted, not lost
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      drops_q <= 16'h0000;
    end else if (wr_drops) begin
      drops_q <= count_drop ? 16'h0001 : 16'h0000;
    end else if (count_drop) begin
      drops_q <= drops_q + 16'h0001;
    end
  end

  assign o_dec_valid  = dvalid_q;
  assign o_dec_drop   = ddrop_q;
  assign o_dec_action = daction_q;
  assign o_dec_vid    = dvid_q;
  assign o_dec_pcp    = dpcp_q;
  assign o_dec_queue  = dqueue_q;

  a_tag_only_drop: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_frm_valid && vlan_en && gbl_q[GBL_TAG_ONLY] && !i_frm_tagged
    |=> o_dec_valid && o_dec_drop)
    else $error("untagged frame passed in tagged-only mode");
  a_filter_drop: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_frm_valid && vlan_en && gbl_q[GBL_FILTER] && !in_member
    |=> o_dec_drop)
    else $error("non-member frame passed the ingress filter");
  a_vlan_off_pass: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_frm_valid && !vlan_en
    |=> !o_dec_drop && o_dec_action == ACT_KEEP &&
        o_dec_vid == $past(i_frm_vid))
    else $error("frame altered with vlan function off");
  a_unmod_keep: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_frm_valid && vlan_en && out_emode == EGR_UNMOD
    |=> o_dec_action == ACT_KEEP && o_dec_pcp == $past(i_frm_pcp))
    else $error("unmodified egress changed the tag");
  a_untag_strip: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_frm_valid && vlan_en && i_frm_tagged && out_emode == EGR_UNTAG
    |=> o_dec_action == ACT_STRIP)
    else $error("untagged egress kept a tag");
  a_retag_vid: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_frm_valid && vlan_en && out_emode == EGR_RETAG
    |=> o_dec_vid == $past(in_pvid) && o_dec_action[1])
    else $error("retagged egress without default vid");
  a_port_prio: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_frm_valid && in_qmode == QOS_PORT_PRIORITY_MODE
    |=> o_dec_queue == $past(port_prio))
    else $error("port priority mode gave wrong queue");

  // scheduler: strict queues first, then weighted round robin
  logic [Q_W-1:0]   cur_q;
  logic [WGT_W-1:0] cnt_q;
  logic             gvalid_q;
  logic [Q_W-1:0]   gqueue_q;
  wire              qos_en = sched_q[SC_QOS_EN];
  wire [NQ-1:0]     smask  = qos_en ? {sched_q[SC_STRICT_Q3],
                             sched_q[SC_STRICT_Q2], 2'b00} : 4'h0;
  wire [NQ-1:0]     sp_pend  = i_q_pending & smask;
  wire [NQ-1:0]     eligible = i_q_pending & ~smask;
  wire              stay     = eligible[cur_q] && (cnt_q != 7'h00);

  logic             nxt_found;
  logic [Q_W-1:0]   nxt_q;
  logic [Q_W-1:0]   cand;
  always_comb begin
    nxt_found = 1'b0;
    nxt_q     = cur_q;
    cand      = cur_q;
    for (int k = 1; k <= NQ; k++) begin
      cand = cur_q + Q_W'(k);
      if (!nxt_found && eligible[cand]) begin
        nxt_found = 1'b1;
        nxt_q     = cand;
      end
    end
  end

  // without qos every queue counts as weight one, plain round robin
  wire [WGT_W-1:0] nxt_wgt = qos_en ? weight_q[WGT_W*nxt_q +: WGT_W] :
                             7'h01;

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      cur_q    <= 2'h0;
      cnt_q    <= 7'h00;
      gvalid_q <= 1'b0;
      gqueue_q <= 2'h0;
    end else begin
      gvalid_q <= 1'b0;
      if (i_sched_req) begin
        if (sp_pend[3]) begin
          gvalid_q <= 1'b1;
          gqueue_q <= 2'h3;
        end else if (sp_pend[2]) begin
          gvalid_q <= 1'b1;
          gqueue_q <= 2'h2;
        end else if (stay) begin
          gvalid_q <= 1'b1;
          gqueue_q <= cur_q;
          cnt_q    <= cnt_q - 7'h01;
        end else if (nxt_found) begin
          gvalid_q <= 1'b1;
          gqueue_q <= nxt_q;
          cur_q    <= nxt_q;
          cnt_q    <= nxt_wgt - 7'h01;
        end
      end
    end
  end

  assign o_grant_valid = gvalid_q;
  assign o_grant_queue = gqueue_q;

  a_weight_nonzero: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    &wgt_nz)
    else $error("scheduler weight of zero");
  a_strict_first: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_sched_req && (sp_pend != 4'h0)
    |=> o_grant_valid && o_grant_queue[1])
    else $error("strict queue not served first");
  a_strict_order: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_sched_req && sp_pend[3] && sp_pend[2]
    |=> o_grant_queue == 2'h3)
    else $error("lower strict queue served before higher");
  a_wrr_burst: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_sched_req && (sp_pend == 4'h0) && stay
    |=> o_grant_valid && o_grant_queue == $past(cur_q))
    else $error("round robin left queue with credit");

endmodule : vlan_qos_core

// ==== core/vlan_qos_pkg.sv ====
package vlan_qos_pkg;

  localparam int VID_W  = 12;
  localparam int PCP_W  = 3;
  localparam int Q_W    = 2;
  localparam int NQ     = 4;
  localparam int WGT_W  = 7;
  localparam int PC_W   = 21;

  localparam logic [VID_W-1:0] VID_MIN  = 12'h001;
  localparam logic [VID_W-1:0] VID_MAX  = 12'hFFE;

  localparam logic [7:0] OFS_GLOBAL = 8'h00;
  localparam logic [7:0] OFS_DROPS  = 8'h04;
  localparam logic [7:0] OFS_TAGMAP = 8'h20;
  localparam logic [7:0] OFS_REMARK = 8'h24;
  localparam logic [7:0] OFS_WEIGHT = 8'h28;
  localparam logic [7:0] OFS_SCHED  = 8'h2C;
  localparam logic [3:0] PORT_PAGE  = 4'h1;
  localparam logic [1:0] VLAN_PAGE  = 2'h1;

  localparam int GBL_VLAN_EN   = 0;
  localparam int GBL_FILTER    = 1;
  localparam int GBL_TAG_AWARE = 2;
  localparam int GBL_TAG_ONLY  = 3;
  localparam int PC_EMODE_LSB  = 12;
  localparam int PC_QMODE_LSB  = 14;
  localparam int PC_PRIO_LSB   = 16;
  localparam int PC_REWRITE    = 18;
  localparam int PC_RX10       = 19;
  localparam int PC_TX10       = 20;
  localparam int VE_MEMB_LSB   = 12;
  localparam int VE_VALID      = 31;
  localparam int SC_STRICT_Q2  = 0;
  localparam int SC_STRICT_Q3  = 1;
  localparam int SC_QOS_EN     = 2;

  localparam logic [3:0]      GLOBAL_RST = 4'h0;
  localparam logic [PC_W-1:0] PORT_RST   = 21'h0_0001;
  localparam logic [15:0]     TAGMAP_RST = 16'hFA50;
  localparam logic [11:0]     REMARK_RST = 12'hD10;
  localparam logic [27:0]     WEIGHT_RST = 28'h020_4081;
  localparam logic [2:0]      SCHED_RST  = 3'h0;

  typedef enum logic [1:0] {EGR_UNMOD, EGR_UNTAG, EGR_TAG, EGR_RETAG}
    egress_mode_t;
  typedef enum logic [1:0] {QOS_OFF, QOS_PORT_PRIORITY_MODE, QOS_TAG,
    QOS_RSVD} qos_mode_t;
  typedef enum logic [1:0] {ACT_KEEP, ACT_STRIP, ACT_INSERT, ACT_REPLACE}
    tag_action_t;

endpackage : vlan_qos_pkg

// ==== bench/link_partner_model.sv ====
`timescale 1ns/1ps
module link_partner_model (
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst,
  input  wire logic        i_en,
  output logic             o_frm_valid,
  output logic [1:0]       o_in_port,
  output logic [1:0]       o_out_port,
  output logic             o_tagged,
  output logic [11:0]      o_vid,
  output logic [2:0]       o_pcp,
  output logic             o_sched_req,
  output logic [3:0]       o_q_pending
);
  // fields are redrawn at random every cycle, whether a frame is valid or not
  initial begin
    {o_frm_valid, o_in_port, o_out_port, o_tagged} = '0;
    {o_vid, o_pcp, o_sched_req, o_q_pending} = '0;
  end
  always @(posedge i_sys_clk) begin
    o_frm_valid <= i_en && !i_rst && $urandom_range(3) != 0;
    o_in_port   <= 2'($urandom_range(3));
    o_out_port  <= 2'($urandom_range(3));
    o_tagged    <= 1'($urandom_range(1));
    // narrow vid range so table hits and misses both occur
    o_vid       <= 12'($urandom_range(9, 1));
    o_pcp       <= 3'($urandom_range(7));
    o_sched_req <= i_en && !i_rst && $urandom_range(1) != 0;
    o_q_pending <= 4'($urandom_range(15));
  end
endmodule : link_partner_model

// ==== bench/trunk_ethernet_vlan_qos_tb.sv ====
`timescale 1ns/1ps
module trunk_ethernet_vlan_qos_tb;
  import vlan_qos_pkg::*;
  logic        clk, rst, rd_s, wr_s, en, wq, fv, ft, sr, dv, dd, gv;
  logic [7:0]  adr;
  logic [31:0] wd, rdat;
  logic [3:0]  be, qp, rx, tx;
  logic [1:0]  fi, fo, da, dq, gq, gqe, cur, n;
  logic [11:0] fvid, dvid;
  logic [2:0]  fpcp, dpcp, sc_s;
  logic [3:0]  gbl_s;
  logic [15:0] drops_s, tm_s;
  logic [11:0] rm_s;
  logic [27:0] wt_s;
  logic [20:0] pc_s [4];
  logic [31:0] vl_s [8];
  logic [19:0] de, dg;
  logic        dp, gp, ge;
  int          cred, fail_count, num_checks;

  vlan_qos_core #(.NPORTS(4), .NVLAN(8)) dut (
    .i_sys_clk(clk), .i_rst(rst), .i_avs_address(adr), .i_avs_read(rd_s),
    .i_avs_write(wr_s), .i_avs_writedata(wd), .i_avs_byteenable(be),
    .o_avs_readdata(rdat), .o_avs_waitrequest(wq), .i_frm_valid(fv),
    .i_frm_in_port(fi), .i_frm_out_port(fo), .i_frm_tagged(ft),
    .i_frm_vid(fvid), .i_frm_pcp(fpcp), .o_dec_valid(dv), .o_dec_drop(dd),
    .o_dec_action(da), .o_dec_vid(dvid), .o_dec_pcp(dpcp), .o_dec_queue(dq),
    .i_sched_req(sr), .i_q_pending(qp), .o_grant_valid(gv),
    .o_grant_queue(gq), .o_rx_rate_10m(rx), .o_tx_rate_10m(tx));
  link_partner_model lp (
    .i_sys_clk(clk), .i_rst(rst), .i_en(en), .o_frm_valid(fv),
    .o_in_port(fi), .o_out_port(fo), .o_tagged(ft), .o_vid(fvid),
    .o_pcp(fpcp), .o_sched_req(sr), .o_q_pending(qp));

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch at %0t got %h exp %h", $time, g, e);
    end
  endtask : chk

  function automatic logic [31:0] rexp(input logic [7:0] a);
    if (a == OFS_GLOBAL) return {28'h0, gbl_s};
    if (a == OFS_DROPS) return {16'h0, drops_s};
    if (a == OFS_TAGMAP) return {16'h0, tm_s};
    if (a == OFS_REMARK) return {20'h0, rm_s};
    if (a == OFS_WEIGHT) return {4'h0, wt_s};
    if (a == OFS_SCHED) return {29'h0, sc_s};
    if (a[7:4] == PORT_PAGE) return {11'h0, pc_s[a[3:2]]};
    if (a[7:6] == VLAN_PAGE && !a[5]) return vl_s[a[4:2]];
    return 32'h0;
  endfunction : rexp

  function automatic void upd(input logic [7:0] a, input logic [31:0] d);
    if (a == OFS_GLOBAL) gbl_s = d[3:0];
    if (a == OFS_DROPS) drops_s = '0;
    if (a == OFS_TAGMAP) tm_s = d[15:0];
    if (a == OFS_REMARK) rm_s = d[11:0];
    if (a == OFS_SCHED) sc_s = d[2:0];
    if (a == OFS_WEIGHT)
      for (int q = 0; q < 4; q++)
        if (d[7*q+:7] != 7'h00) wt_s[7*q+:7] = d[7*q+:7];
    if (a[7:4] == PORT_PAGE) begin
      pc_s[a[3:2]][20:12] = d[20:12];
      if (d[11:0] >= VID_MIN && d[11:0] <= VID_MAX)
        pc_s[a[3:2]][11:0] = d[11:0];
    end
    if (a[7:6] == VLAN_PAGE && !a[5]) vl_s[a[4:2]] = d & 32'h8000_FFFF;
  endfunction : upd

  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [3:0] b);
    int k;
    @(posedge clk);
    adr <= a;
    wd <= d;
    be <= b;
    wr_s <= w;
    rd_s <= !w;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (wq !== 1'b0);
    chk(32'(k), 32'h0000_0002);
    if (!w) chk(rdat, rexp(a));
    else if (b == 4'hF) upd(a, d);
    rd_s <= 1'b0;
    wr_s <= 1'b0;
  endtask : bus

  function automatic logic [19:0] dec(input logic [1:0] ip, op,
    input logic tg, input logic [11:0] v, input logic [2:0] pr);
    logic [11:0] cv;
    logic [3:0]  mb;
    logic [1:0]  q, act, qm;
    logic        dr;
    logic [2:0]  po;
    cv = (gbl_s[2] && tg) ? v : pc_s[ip][11:0];
    mb = '0;
    for (int e = 0; e < 8; e++)
      if (vl_s[e][31] && vl_s[e][11:0] == cv) mb |= vl_s[e][15:12];
    qm = pc_s[ip][15:14];
    q = '0;
    if (qm == 2'd1 || (qm == 2'd2 && !tg)) q = pc_s[ip][17:16];
    else if (qm == 2'd2) q = tm_s[2*pr+:2];
    act = '0;
    if (gbl_s[0])
      case (pc_s[op][13:12])
        2'd1:    act = tg ? 2'd1 : 2'd0;
        2'd2:    act = tg ? 2'd0 : 2'd2;
        2'd3:    act = tg ? 2'd3 : 2'd2;
        default: act = 2'd0;
      endcase
    dr = gbl_s[0] && ((gbl_s[3] && !tg) || (gbl_s[1] && !mb[ip]) || !mb[op]);
    po = pr;
    if (act == 2'd2 || (act == 2'd3 && pc_s[op][18])) po = rm_s[3*q+:3];
    return {dr, act, (act[1] ? pc_s[ip][11:0] : v), po, q};
  endfunction : dec

  function automatic logic strict(input logic [1:0] k);
    return sc_s[2] && ((k == 2'd2 && sc_s[0]) || (k == 2'd3 && sc_s[1]));
  endfunction : strict

  function automatic logic [6:0] wgt(input int r);
    return (r == 1) ? 7'h7F : 7'($urandom_range(3, 1));
  endfunction : wgt

  always @(posedge clk) begin
    if (rst) begin
      dp = 1'b0;
      gp = 1'b0;
      cur = 2'd0;
      cred = 0;
    end else begin
      dg = {dd, da, dvid, dpcp, dq};
      chk(32'(dv), 32'(dp));
      if (dp) begin
        chk(32'(dg[19]), 32'(de[19]));
        chk(32'(dg[18:2]), 32'(de[18:2]));
        chk(32'(dg[1:0]), 32'(de[1:0]));
        if (de[19]) drops_s++;
      end
      chk(32'(gv), 32'(gp && ge));
      if (gp && ge) chk(32'(gq), 32'(gqe));
      dp = fv;
      if (fv) de = dec(fi, fo, ft, fvid, fpcp);
      gp = sr;
      ge = 1'b0;
      if (sr) begin
        if (sc_s[2] && sc_s[1] && qp[3]) begin
          ge = 1'b1;
          gqe = 2'd3;
        end else if (sc_s[2] && sc_s[0] && qp[2]) begin
          ge = 1'b1;
          gqe = 2'd2;
        end else if (cred > 0 && qp[cur] && !strict(cur)) begin
          ge = 1'b1;
          gqe = cur;
          cred--;
        end else
          for (int k = 1; k < 5; k++) begin
            n = cur + 2'(k);
            if (!ge && qp[n] && !strict(n)) begin
              ge = 1'b1;
              gqe = n;
              cred = sc_s[2] ? int'(wt_s[7*n+:7]) - 1 : 0;
            end
          end
        if (ge && !(gqe[1] && strict(gqe))) cur = gqe;
      end
    end
  end

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // six rounds take about 5000 cycles; eight times that means a hang
  initial begin
    #(20 * 40000);
    fail_count++;
    end_of_test();
  end

  initial begin
    {rst, rd_s, wr_s, en, adr, wd, be} = '0;
    rst = 1'b1;
    fail_count = 0;
    num_checks = 0;
    void'($urandom(62764));
    for (int r = 0; r < 6; r++) begin
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      {gbl_s, drops_s, tm_s} = {GLOBAL_RST, 16'h0000, TAGMAP_RST};
      {rm_s, wt_s, sc_s} = {REMARK_RST, WEIGHT_RST, SCHED_RST};
      for (int p = 0; p < 4; p++) pc_s[p] = PORT_RST;
      for (int e = 0; e < 8; e++) vl_s[e] = '0;
      for (int a = 0; a < 256; a += 4) bus(0, 8'(a), 0, 4'hF);
      bus(1, OFS_GLOBAL, 32'h0000_000F, 4'h3);
      bus(1, 8'h10, 32'h0010_0000, 4'hF);
      bus(1, 8'h14, 32'h0000_0FFF, 4'hF);
      bus(1, 8'h18, 32'h0000_0FFE, 4'hF);
      bus(1, OFS_WEIGHT, 32'h0FE0_0000, 4'hF);
      for (int a = 0; a < 48; a += 4) bus(0, 8'(a), 0, 4'hF);
      bus(1, OFS_GLOBAL, 32'($urandom_range(15)), 4'hF);
      for (int p = 0; p < 4; p++)
        bus(1, 8'(16 + 4 * p), {11'h0, 5'($urandom), 2'(p + r + 1),
            2'(p + r), 12'($urandom_range(9, 1))}, 4'hF);
      for (int e = 0; e < 8; e++)
        bus(1, 8'(64 + 4 * e), {1'($urandom), 15'($urandom),
            4'($urandom), 12'(e + 1)}, 4'hF);
      bus(1, OFS_TAGMAP, $urandom, 4'hF);
      bus(1, OFS_REMARK, $urandom, 4'hF);
      bus(1, OFS_WEIGHT, {4'h0, wgt(r), wgt(r), wgt(r), wgt(r)}, 4'hF);
      bus(1, OFS_SCHED, {29'h0, 1'(r), 2'($urandom)}, 4'hF);
      for (int a = 0; a < 256; a += 4) bus(0, 8'(a), 0, 4'hF);
      for (int p = 0; p < 4; p++) begin
        chk(32'(rx[p]), 32'(pc_s[p][PC_RX10]));
        chk(32'(tx[p]), 32'(pc_s[p][PC_TX10]));
      end
      en <= 1'b1;
      repeat (300) @(posedge clk);
      en <= 1'b0;
      repeat (4) @(posedge clk);
      bus(0, OFS_DROPS, 0, 4'hF);
      bus(1, OFS_DROPS, 0, 4'hF);
      bus(0, OFS_DROPS, 0, 4'hF);
    end
    end_of_test();
  end
endmodule : trunk_ethernet_vlan_qos_tb
